/* rtl/tsio_top.sv */
// How it works
// - lamp_on goes high while the software lamp-enable bit is set.
// - periodic_strobe_out toggles on a divider of the master clock, giving a periodic pulse.
// - delayed_strobe_out pulses once per integration period after a programmed delay.
// - in external hardware trigger mode a rising edge on trigger_input starts a period.
// - in software trigger mode trigger_input is an active-high level gating triggers.
// - in external sync or level mode each rising edge of trigger_input bounds a period.
// - eight gpio pins are each set as input or output by software.
// - delayed_strobe_out is held low unless lamp enable is on.
// - the strobe rises at strobe_rise_delay and falls at strobe_fall_delay, in 500 ns steps.
`timescale 1ns/1ns
`default_nettype none
module tsio_top
  import tsio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_input,
  input wire logic int_period_start,
  output logic lamp_on,
  output logic periodic_strobe_out,
  output logic delayed_strobe_out,
  output logic period_start,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe
);
  logic [31:0] ctrl_q;
  logic [15:0] rise_q;
  logic [15:0] fall_q;
  logic [31:0] div_q;
  logic [7:0] gpdir_q;
  logic [7:0] gpout_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic [31:0] pdiv_cnt_q;
  logic [7:0] step_cnt_q;
  logic [15:0] steps_q;
  logic running_q;
  logic [31:0] rdata_d;
  logic slverr_d;

  wire tsio_mode_type mode = tsio_mode_type'(ctrl_q[CTRL_MODE_LO +: 3]);
  wire lamp_en = ctrl_q[CTRL_LAMP];
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_rise = (paddr == ADDR_RISE);
  wire sel_fall = (paddr == ADDR_FALL);
  wire sel_div = (paddr == ADDR_DIV);
  wire sel_gpdir = (paddr == ADDR_GPDIR);
  wire sel_gpout = (paddr == ADDR_GPOUT);
  wire sel_gpin = (paddr == ADDR_GPIN);
  wire sel_stat = (paddr == ADDR_STAT);
  wire addr_ok = sel_ctrl | sel_rise | sel_fall | sel_div | sel_gpdir | sel_gpout
    | sel_gpin | sel_stat;
  // write-one trigger: bit 4 is never stored, so a readback cannot fire it again
  wire sw_trig = wr_en & sel_ctrl & pwdata[CTRL_SWTRIG];
  // edge detection on the second and third stages only
  wire trig_rise = sync2_q & ~sync3_q;
  wire start_d =
    ((mode == TSIO_MODE_EXT_HW) & trig_rise)
    | ((mode == TSIO_MODE_SOFT) & sync2_q & (sw_trig | int_period_start))
    | (((mode == TSIO_MODE_EXT_SYNC) | (mode == TSIO_MODE_EXT_LEVEL)) & trig_rise)
    | ((mode == TSIO_MODE_NORMAL) & (sw_trig | int_period_start));
  wire step_tick = (step_cnt_q == 8'(STEP_CYC - 1));
  wire strobe_hi = running_q & (steps_q >= rise_q) & (steps_q < fall_q);
  // >= so that a smaller divisor written mid-count takes effect at once
  wire div_tick = (pdiv_cnt_q >= div_q);

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: rdata_d = {28'h0000000, ctrl_q[3:0]};
      ADDR_RISE: rdata_d = {16'h0000, rise_q};
      ADDR_FALL: rdata_d = {16'h0000, fall_q};
      ADDR_DIV: rdata_d = div_q;
      ADDR_GPDIR: rdata_d = {24'h000000, gpdir_q};
      ADDR_GPOUT: rdata_d = {24'h000000, gpout_q};
      ADDR_GPIN: rdata_d = {24'h000000, gpio_in};
      ADDR_STAT: rdata_d = {15'h0000, running_q, steps_q};
      default: rdata_d = 32'h0000_0000;
    endcase
    slverr_d = ~addr_ok;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= 32'h0000_0000;
      rise_q <= RISE_RESET;
      fall_q <= FALL_RESET;
      div_q <= DIV_RESET;
      gpdir_q <= 8'h00;
      gpout_q <= 8'h00;
    end
    else if (wr_en)
    begin
      // trigger bit is self-clearing, never stored
      if (sel_ctrl) ctrl_q <= {28'h0000000, pwdata[3:0]};
      if (sel_rise) rise_q <= pwdata[15:0];
      if (sel_fall) fall_q <= pwdata[15:0];
      if (sel_div) div_q <= pwdata;
      if (sel_gpdir) gpdir_q <= pwdata[7:0];
      if (sel_gpout) gpout_q <= pwdata[7:0];
    end
  end

  // zero-wait slave: read data registered at the end of the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
      pslverr <= psel & ~penable & slverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      // only the second stage reads the first; the third serves the edge detector
      sync1_q <= trigger_input;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdiv_cnt_q <= 32'h0000_0000;
      periodic_strobe_out <= 1'b0;
    end
    else if (div_tick)
    begin
      pdiv_cnt_q <= 32'h0000_0000;
      periodic_strobe_out <= ~periodic_strobe_out;
    end
    else
      pdiv_cnt_q <= pdiv_cnt_q + 32'h0000_0001;
  end

  // a new period restarts the step timer even mid-pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt_q <= 8'h00;
      steps_q <= 16'h0000;
      running_q <= 1'b0;
      period_start <= 1'b0;
    end
    else
    begin
      period_start <= start_d;
      if (start_d)
      begin
        step_cnt_q <= 8'h00;
        steps_q <= 16'h0000;
        running_q <= 1'b1;
      end
      else if (running_q)
      begin
        step_cnt_q <= step_tick ? 8'h00 : step_cnt_q + 8'h01;
        if (step_tick)
        begin
          // the all-ones guard keeps the step count from wrapping into a new window
          if (steps_q == 16'hFFFF || steps_q >= fall_q)
            running_q <= 1'b0;
          else
            steps_q <= steps_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lamp_on <= 1'b0;
      delayed_strobe_out <= 1'b0;
      gpio_out <= 8'h00;
      gpio_oe <= 8'h00;
    end
    else
    begin
      lamp_on <= lamp_en;
      // gating at the output lets a lamp-off write cut a running pulse short
      delayed_strobe_out <= lamp_en & strobe_hi;
      gpio_out <= gpout_q;
      gpio_oe <= gpdir_q;
    end
  end

  AST_LAMP_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 lamp_on == $past(lamp_en))
    else $error("lamp_on does not follow enable");
  AST_STROBE_NEEDS_LAMP: assert property (@(posedge pclk) disable iff (!presetn)
    delayed_strobe_out |-> $past(lamp_en))
    else $error("strobe without lamp enable");
  AST_STROBE_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
    delayed_strobe_out |-> ($past(steps_q) >= $past(rise_q)) && ($past(steps_q) < $past(fall_q)))
    else $error("strobe outside its delay window");
  AST_HW_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == TSIO_MODE_EXT_HW && sync2_q && !sync3_q) |=> period_start && running_q)
    else $error("rising edge did not start a period");
  AST_SOFT_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == TSIO_MODE_SOFT && !sync2_q) |=> !period_start)
    else $error("soft trigger taken with level low");
  AST_SYNC_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode == TSIO_MODE_EXT_SYNC) && sync2_q && !sync3_q) |=> period_start)
    else $error("sync clock edge missed");
  AST_GPIO_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_GPDIR) |=> ##1 gpio_oe == $past(pwdata[7:0], 2))
    else $error("gpio direction not applied");
  AST_SYNC_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 sync2_q == $past(trigger_input, 2))
    else $error("trigger synchroniser depth wrong");
  AST_PSTROBE_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    div_tick |=> periodic_strobe_out != $past(periodic_strobe_out))
    else $error("periodic strobe did not toggle");
  AST_PERIOD_RUNS: assert property (@(posedge pclk) disable iff (!presetn)
    start_d |=> running_q && steps_q == 16'h0000)
    else $error("period did not restart");

  // bus side: one wait-free access per transfer
  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("pready missing after setup");

  AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !addr_ok) |=> pslverr)
    else $error("unmapped address not refused");

  AST_APB_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  AST_GPIN_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && sel_gpin) |-> prdata == {24'h000000, $past(gpio_in)})
    else $error("gpio input readback wrong");

  AST_GPIO_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_gpout) |=> ##1 gpio_out == $past(pwdata[7:0], 2))
    else $error("gpio output value not applied");

  AST_LEVEL_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode == TSIO_MODE_EXT_LEVEL) && sync2_q && !sync3_q) |=> period_start)
    else $error("level-mode clock edge missed");

  AST_SOFT_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == TSIO_MODE_SOFT && sync2_q && (sw_trig || int_period_start)) |=> period_start)
    else $error("soft trigger with level high ignored");

  AST_HW_EDGE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == TSIO_MODE_EXT_HW && !(sync2_q && !sync3_q)) |=> !period_start)
    else $error("period started without a rising edge");

  AST_STROBE_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    (lamp_en && running_q && steps_q >= rise_q && steps_q < fall_q) |=> delayed_strobe_out)
    else $error("strobe missing inside its window");

  AST_STEP_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (running_q && !start_d && step_tick && steps_q < fall_q)
    |=> steps_q == $past(steps_q) + 16'h0001)
    else $error("step count did not advance");

  AST_STEP_END: assert property (@(posedge pclk) disable iff (!presetn)
    (running_q && !start_d && step_tick && steps_q >= fall_q) |=> !running_q)
    else $error("period timer ran past the fall delay");

  AST_IDLE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !running_q |=> !delayed_strobe_out)
    else $error("strobe outside an integration period");

  AST_PSTROBE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !div_tick |=> $stable(periodic_strobe_out))
    else $error("periodic strobe changed between divider ticks");
endmodule
`default_nettype wire

/* rtl/tsio_pkg.sv */
package tsio_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned STEP_NS = 500;
  localparam int unsigned STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_RISE = 12'h004;
  localparam logic [11:0] ADDR_FALL = 12'h008;
  localparam logic [11:0] ADDR_DIV = 12'h00C;
  localparam logic [11:0] ADDR_GPDIR = 12'h010;
  localparam logic [11:0] ADDR_GPOUT = 12'h014;
  localparam logic [11:0] ADDR_GPIN = 12'h018;
  localparam logic [11:0] ADDR_STAT = 12'h01C;
  localparam int unsigned CTRL_LAMP = 0;
  localparam int unsigned CTRL_MODE_LO = 1;
  localparam int unsigned CTRL_SWTRIG = 4;
  localparam logic [31:0] DIV_RESET = 32'h0000_0FA0;
  localparam logic [15:0] RISE_RESET = 16'h0000;
  localparam logic [15:0] FALL_RESET = 16'h0001;
  typedef enum logic [2:0]
  {
    TSIO_MODE_NORMAL = 3'h0,
    TSIO_MODE_SOFT = 3'h1,
    TSIO_MODE_EXT_SYNC = 3'h2,
    TSIO_MODE_EXT_HW = 3'h3,
    TSIO_MODE_EXT_LEVEL = 3'h4
  } tsio_mode_type;
endpackage

/* dv/tsio_trig_src.sv */
`timescale 1ns/1ns
`default_nettype none
// far-side trigger source: a free clock while run is high, else a plain level
module tsio_trig_src #(parameter int HALF = 400)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic level_high,
  output logic trigger_input
);
  int cnt_q;
  logic clk_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 0;
      clk_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 0;
      clk_q <= 1'b0;
    end
    else if (cnt_q == HALF - 1)
    begin
      cnt_q <= 0;
      clk_q <= ~clk_q;
    end
    else
      cnt_q <= cnt_q + 1;
  end
  assign trigger_input = run ? clk_q : level_high;
endmodule
`default_nettype wire

/* dv/tb_tsio_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_tsio_top;
  import tsio_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, lvl = 0, ips = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, trig, lamp_on, cstb, dstb, pstart;
  logic [7:0] gpio_in = 8'h3C, gpio_out, gpio_oe;
  int mismatches = 0, n_compared = 0, n_hi, n_ps;
  tsio_top i_tsio_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_input(trig), .int_period_start(ips), .lamp_on(lamp_on),
    .periodic_strobe_out(cstb), .delayed_strobe_out(dstb), .period_start(pstart),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  tsio_trig_src i_tsio_trig_src (.pclk(pclk), .presetn(presetn), .run(run),
    .level_high(lvl), .trigger_input(trig));
  initial forever #2 pclk = ~pclk;
  task report_and_stop;
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task watch(input int cyc);
    n_hi = 0;
    n_ps = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      n_hi += int'(dstb === 1'b1);
      n_ps += int'(pstart === 1'b1);
    end
  endtask
  task t_reset;
    chk({31'h0, lamp_on}, 32'h0);
    apb(1'b0, ADDR_RISE, 32'h0);
    chk(rd, {16'h0, RISE_RESET});
    apb(1'b0, ADDR_FALL, 32'h0);
    chk(rd, {16'h0, FALL_RESET});
    apb(1'b0, ADDR_DIV, 32'h0);
    chk(rd, DIV_RESET);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task t_lamp_and_div;
    logic s;
    int n;
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, lamp_on}, 32'h1);
    apb(1'b1, ADDR_DIV, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      s = cstb;
      n = 0;
      while (cstb === s && n < 100)
      begin
        @(posedge pclk);
        n++;
      end
      if (i > 0)
        chk(n, 32'h4);
    end
  endtask
  task t_ext;
    int n;
    apb(1'b1, ADDR_RISE, 32'h1);
    apb(1'b1, ADDR_FALL, 32'h2);
    apb(1'b1, ADDR_CTRL, {28'h0, TSIO_MODE_EXT_HW, 1'b1});
    run <= 1'b1;
    n = 0;
    while (dstb !== 1'b1 && n++ < 3000) @(posedge pclk);
    n = 0;
    while (dstb === 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n, STEP_CYC);
    // window starts where one pulse ended, so two whole pulses fall inside it
    watch(1600);
    chk(n_hi, 2 * STEP_CYC);
    chk(n_ps, 32'h2);
    apb(1'b1, ADDR_CTRL, {28'h0, TSIO_MODE_EXT_HW, 1'b0});
    watch(1600);
    chk(n_hi, 32'h0);
    apb(1'b1, ADDR_CTRL, {28'h0, TSIO_MODE_EXT_SYNC, 1'b1});
    watch(1600);
    chk(n_ps, 32'h2);
    apb(1'b1, ADDR_CTRL, {28'h0, TSIO_MODE_EXT_LEVEL, 1'b1});
    watch(1600);
    chk(n_ps, 32'h2);
    run <= 1'b0;
  endtask
  task t_midreset;
    lvl <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({24'h0, gpio_oe}, 32'h0);
    chk({31'h0, lamp_on}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_GPDIR, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_soft_and_gpio;
    apb(1'b1, ADDR_CTRL, 32'h13);
    watch(20);
    chk(n_ps, 32'h0);
    ips <= 1'b1;
    @(posedge pclk);
    ips <= 1'b0;
    watch(20);
    chk(n_ps, 32'h0);
    lvl <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b1, ADDR_CTRL, 32'h13);
    watch(20);
    chk(n_ps, 32'h1);
    ips <= 1'b1;
    @(posedge pclk);
    ips <= 1'b0;
    watch(20);
    chk(n_ps, 32'h1);
    apb(1'b1, ADDR_GPDIR, 32'h0F);
    apb(1'b1, ADDR_GPOUT, 32'hA5);
    repeat (2) @(posedge pclk);
    chk({24'h0, gpio_oe}, 32'h0F);
    chk({24'h0, gpio_out & gpio_oe}, 32'h05);
    apb(1'b0, ADDR_GPIN, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h3C);
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_lamp_and_div;
    t_ext;
    t_soft_and_gpio;
    t_midreset;
    report_and_stop;
  end
  // the run needs about 7200 cycles
  initial
  begin
    #200000;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
